// *** hw/chg_pkg.sv ***
// Constants, register layout and carrier types for the charger control block.
// Assumes a 20 MHz control clock and an I2C link clocked by the host's SCL.
package chg_pkg;

  // Link addressing and register offsets.
  localparam logic [6:0] CHG_I2C_ADDR = 7'h5C;
  localparam logic [7:0] CHG_OFF_GLOBAL_RESET = 8'h00;
  localparam logic [7:0] CHG_OFF_OPMODE = 8'h01;

  // Reset values and writable-bit masks.
  localparam logic [7:0] CHG_GLOBAL_RESET_DEFAULT = 8'h00;
  localparam logic [7:0] CHG_OPMODE_DEFAULT = 8'h10;
  localparam logic [7:0] CHG_OPMODE_WMASK = 8'hDF;
  localparam int CHG_RST_BIT = 7;
  localparam logic [6:0] CHG_RSVD_ZERO = 7'h00;

  // Bit counter values of the acknowledge slot and of the first bit.
  localparam logic [3:0] CHG_BIT_ACK = 4'h8;
  localparam logic [3:0] CHG_BIT_FIRST = 4'h1;

  // Interrupt reminder timing.
  localparam int CHG_CLK_HZ = 20_000_000;
  localparam int CHG_REMIND_PERIOD_S = 2;
  localparam int CHG_REMIND_CYC = CHG_REMIND_PERIOD_S * CHG_CLK_HZ;
  localparam int CHG_INT_RELEASE_US = 1;
  localparam int CHG_INT_RELEASE_CYC =
    CHG_INT_RELEASE_US * (CHG_CLK_HZ / 1_000_000);

  // Operating mode register, most significant bit first.
  typedef struct packed {
    logic switch_freq_select;
    logic fixed_freq_force;
    logic rsvd5;
    logic stat_pin_enable;
    logic int_reminder_enable;
    logic high_impedance_select;
    logic boost_pin_gating;
    logic boost_select;
  } chg_opmode_type;

  // One register write carried from the link to the control domain.
  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] data;
  } chg_wr_type;

endpackage : chg_pkg

// *** hw/chg_i2c_link.sv ***
// I2C target logic that runs on the host's SCL and serves the control bytes.
// Assumes SCL only toggles inside frames and the register image is held
// stable by the control domain while its publish toggle settles.
`timescale 1ns/1ps
module chg_i2c_link
  import chg_pkg::*;
(
  // Link pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic link_clr_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Register image from the control domain
  input wire logic pub_tog_i,
  input wire logic [7:0] img_global_i,
  input wire logic [7:0] img_opmode_i,
  // Write requests to the control domain
  output logic wr_tog_o,
  output chg_wr_type wr_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_OFFS, ST_WDATA, ST_RDATA
  } chg_link_state_type;

  chg_link_state_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, tx_r, tx_nxt;
  logic [7:0] img0_r, img1_r;
  logic start_tog_r, start_seen_r, pub_s1_r, pub_s2_r, pub_seen_r;
  logic wr_fire;

  function automatic logic [7:0] img_byte(input logic [7:0] offs,
    input logic [7:0] g, input logic [7:0] m);
    img_byte = (offs == CHG_OFF_GLOBAL_RESET) ? g :
      (offs == CHG_OFF_OPMODE) ? m : 8'h00;
  endfunction : img_byte

  wire logic new_frame = start_tog_r ^ start_seen_r;
  wire logic at_ack = cnt_r == CHG_BIT_ACK;
  wire logic addr_hit = shift_r[7:1] == CHG_I2C_ADDR;
  wire logic ack_due = at_ack && ((state_r == ST_ADDR && addr_hit) ||
    state_r == ST_OFFS || state_r == ST_WDATA);
  wire logic drive_low = ack_due ||
    (state_r == ST_RDATA && !at_ack && !tx_r[7]);

  // A start is an SDA fall while SCL is high; the toggle is seen on SCL.
  always_ff @(negedge sda_i or posedge link_clr_i)
  begin
    if (link_clr_i) start_tog_r <= 1'b0;
    else if (scl_i) start_tog_r <= ~start_tog_r;
  end

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    wr_fire = 1'b0;
    if (new_frame)
    begin
      state_nxt = ST_ADDR;
      cnt_nxt = CHG_BIT_FIRST;
      shift_nxt = {7'h00, sda_i};
    end
    else if (state_r != ST_IDLE && !at_ack)
    begin
      cnt_nxt = cnt_r + CHG_BIT_FIRST;
      if (state_r == ST_RDATA) tx_nxt = {tx_r[6:0], 1'b0};
      else shift_nxt = {shift_r[6:0], sda_i};
    end
    else if (state_r != ST_IDLE)
    begin
      cnt_nxt = 4'h0;
      case (state_r)
        ST_ADDR:
        begin
          if (!addr_hit) state_nxt = ST_IDLE;
          else if (shift_r[0])
          begin
            state_nxt = ST_RDATA;
            tx_nxt = img_byte(ptr_r, img0_r, img1_r);
          end
          else state_nxt = ST_OFFS;
        end
        ST_OFFS:
        begin
          ptr_nxt = shift_r;
          state_nxt = ST_WDATA;
        end
        ST_WDATA:
        begin
          wr_fire = 1'b1;
          ptr_nxt = ptr_r + 8'h01;
        end
        ST_RDATA:
        begin
          if (sda_i) state_nxt = ST_IDLE;
          else
          begin
            ptr_nxt = ptr_r + 8'h01;
            tx_nxt = img_byte(ptr_r + 8'h01, img0_r, img1_r);
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl_i or posedge link_clr_i)
  begin
    if (link_clr_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      start_seen_r <= 1'b0;
      wr_tog_o <= 1'b0;
      wr_o <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      start_seen_r <= start_tog_r;
      if (wr_fire) wr_tog_o <= ~wr_tog_o;
      if (wr_fire) wr_o <= '{offset: ptr_r, data: shift_r};
    end
  end

  // The image is taken only once its toggle has passed two flip-flops.
  always_ff @(posedge scl_i or posedge link_clr_i)
  begin
    if (link_clr_i)
    begin
      {pub_s1_r, pub_s2_r, pub_seen_r} <= 3'h0;
      img0_r <= CHG_GLOBAL_RESET_DEFAULT;
      img1_r <= CHG_OPMODE_DEFAULT;
    end
    else
    begin
      {pub_s1_r, pub_s2_r, pub_seen_r} <= {pub_tog_i, pub_s1_r, pub_s2_r};
      if (pub_s2_r ^ pub_seen_r) img0_r <= img_global_i;
      if (pub_s2_r ^ pub_seen_r) img1_r <= img_opmode_i;
    end
  end

  always_ff @(negedge scl_i or posedge link_clr_i)
  begin
    if (link_clr_i)
    begin
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      sda_oe_o <= drive_low;
      sda_o <= 1'b0;
    end
  end

  a_foreign_addr: assert property (@(posedge scl_i)
    disable iff (link_clr_i)
    state_r == ST_ADDR && at_ack && !addr_hit && !new_frame
    |=> state_r == ST_IDLE)
    else $error("Link stayed busy after a foreign address.");

  c_link_write: cover property (@(posedge scl_i) disable iff (link_clr_i)
    wr_fire);

endmodule : chg_i2c_link

// *** hw/chg_core_ctrl.sv ***
// Control register bank of the charger core: global reset and operating mode.
// Assumes an I2C host on SCL/SDA and charger logic that raises irq_pending_i.
// Functional notes
// - Device answers the I2C target address 1011100 only.
// - Writing one to the global reset bit restores every register default.
// - The global reset bit clears itself once the reset has been done.
// - A reset requested in high-impedance mode waits until that mode ends.
// - Operating bit 7 picks 1.5MHz when zero, 0.75MHz when one.
// - Fixed-frequency bit one keeps the charge switching frequency fixed.
// - Operating bit 4 enables the charge status pin function.
// - Reminder off keeps the interrupt asserted until it is serviced.
// - Reminder on releases and reasserts a pending interrupt every 2s.
// - Operating bit 2 one places the charger in high-impedance mode.
// - With pin gating, boost needs the boost select bit and OTG pin.
// - Operating bit 0 selects charge mode at zero, boost at one.
`timescale 1ns/1ps
module chg_core_ctrl
  import chg_pkg::*;
#(
  parameter int REMIND_CYCLES = CHG_REMIND_CYC,
  parameter int RELEASE_CYCLES = CHG_INT_RELEASE_CYC
)
(
  // Control clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // I2C link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Charger pins and events
  input wire logic otg_pin_i,
  input wire logic irq_pending_i,
  output logic int_n_o,
  // Operating controls
  output logic switch_freq_select_o,
  output logic fixed_freq_force_o,
  output logic stat_pin_enable_o,
  output logic high_impedance_select_o,
  output logic boost_mode_o,
  output logic reset_busy_o
);

  localparam int CNT_W = $clog2(REMIND_CYCLES);
  localparam logic [CNT_W-1:0] REM_LAST = CNT_W'(REMIND_CYCLES - 1);
  localparam logic [CNT_W-1:0] REL_START =
    CNT_W'(REMIND_CYCLES - RELEASE_CYCLES);

  chg_opmode_type opmode_r, opmode_nxt;
  chg_wr_type wr_word;
  logic rst_pend_r, rst_pend_nxt;
  logic link_clr_r;
  logic wr_tog, wr_s1_r, wr_s2_r, wr_s3_r;
  logic otg_s1_r, otg_s2_r;
  logic boost_mode_r, int_n_r;
  logic pub_tog_r;
  logic [7:0] img_global_r, img_opmode_r;
  logic [15:0] img_prev_r;
  logic [CNT_W-1:0] rem_cnt_r, rem_cnt_nxt;

  // The link logic has no free-running clock, so it is cleared directly.
  always_ff @(posedge clk_i)
  begin
    link_clr_r <= ~rst_n_i;
  end

  chg_i2c_link chg_i2c_link_inst (
    .scl_i(scl_i),
    .sda_i(sda_i),
    .link_clr_i(link_clr_r),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .pub_tog_i(pub_tog_r),
    .img_global_i(img_global_r),
    .img_opmode_i(img_opmode_r),
    .wr_tog_o(wr_tog),
    .wr_o(wr_word)
  );

  // Write decode; the word is stable while its toggle crosses.
  wire logic wr_fire = wr_s2_r ^ wr_s3_r;
  wire logic wr_global = wr_fire && wr_word.offset == CHG_OFF_GLOBAL_RESET;
  wire logic wr_opmode = wr_fire && wr_word.offset == CHG_OFF_OPMODE;
  wire chg_opmode_type wr_op_val =
    chg_opmode_type'(wr_word.data & CHG_OPMODE_WMASK);
  wire logic wr_rst_req = wr_global && wr_word.data[CHG_RST_BIT];
  wire logic rst_fire =
    rst_pend_r && !opmode_r.high_impedance_select && !wr_fire;

  // A host write in the same cycle wins over the pending reset.
  always_comb
  begin
    opmode_nxt = opmode_r;
    rst_pend_nxt = rst_pend_r;
    if (rst_fire)
    begin
      opmode_nxt = chg_opmode_type'(CHG_OPMODE_DEFAULT);
      rst_pend_nxt = 1'b0;
    end
    else
    begin
      if (wr_opmode) opmode_nxt = wr_op_val;
      if (wr_rst_req) rst_pend_nxt = 1'b1;
    end
  end

  wire logic boost_nxt =
    opmode_r.boost_select && (!opmode_r.boost_pin_gating || otg_s2_r);

  wire logic remind_on = irq_pending_i && opmode_r.int_reminder_enable;
  always_comb
  begin
    rem_cnt_nxt = rem_cnt_r + CNT_W'(1);
    if (!remind_on || rem_cnt_r == REM_LAST) rem_cnt_nxt = '0;
  end
  wire logic int_n_nxt =
    !irq_pending_i || (remind_on && rem_cnt_r >= REL_START);

  wire logic [15:0] img_now = {rst_pend_r, CHG_RSVD_ZERO, opmode_r};
  // A value must stand two cycles before it is published. A reset that
  // fires right after its request would otherwise toggle twice while SCL
  // is idle, and the link would miss both changes.
  wire logic img_stale = img_now != {img_global_r, img_opmode_r} &&
    img_now == img_prev_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      img_prev_r <= {CHG_GLOBAL_RESET_DEFAULT, CHG_OPMODE_DEFAULT};
    else
      img_prev_r <= img_now;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      opmode_r <= chg_opmode_type'(CHG_OPMODE_DEFAULT);
      rst_pend_r <= CHG_GLOBAL_RESET_DEFAULT[CHG_RST_BIT];
    end
    else
    begin
      opmode_r <= opmode_nxt;
      rst_pend_r <= rst_pend_nxt;
    end
  end

  // Incoming toggle and OTG pin each pass two flip-flops first.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {wr_s1_r, wr_s2_r, wr_s3_r} <= 3'h0;
      {otg_s1_r, otg_s2_r} <= 2'h0;
    end
    else
    begin
      {wr_s1_r, wr_s2_r, wr_s3_r} <= {wr_tog, wr_s1_r, wr_s2_r};
      {otg_s1_r, otg_s2_r} <= {otg_pin_i, otg_s1_r};
    end
  end

  // The read image changes only with its toggle, so SCL sees whole bytes.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pub_tog_r <= 1'b0;
      img_global_r <= CHG_GLOBAL_RESET_DEFAULT;
      img_opmode_r <= CHG_OPMODE_DEFAULT;
    end
    else if (img_stale)
    begin
      pub_tog_r <= ~pub_tog_r;
      {img_global_r, img_opmode_r} <= img_now;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      boost_mode_r <= 1'b0;
      int_n_r <= 1'b1;
      rem_cnt_r <= '0;
    end
    else
    begin
      boost_mode_r <= boost_nxt;
      int_n_r <= int_n_nxt;
      rem_cnt_r <= rem_cnt_nxt;
    end
  end

  assign switch_freq_select_o = opmode_r.switch_freq_select;
  assign fixed_freq_force_o = opmode_r.fixed_freq_force;
  assign stat_pin_enable_o = opmode_r.stat_pin_enable;
  assign high_impedance_select_o = opmode_r.high_impedance_select;
  assign boost_mode_o = boost_mode_r;
  assign int_n_o = int_n_r;
  assign reset_busy_o = rst_pend_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reset_defaults: assert property (rst_fire
    |=> opmode_r == chg_opmode_type'(CHG_OPMODE_DEFAULT))
    else $error("Global reset did not restore defaults.");

  a_zero_write: assert property (wr_global
    && !wr_word.data[CHG_RST_BIT] && !rst_pend_r
    |=> !reset_busy_o && $stable(opmode_r))
    else $error("Writing zero to the reset bit changed a register.");

  a_reset_selfclr: assert property (wr_rst_req
    && !opmode_nxt.high_impedance_select ##1 !wr_fire [*2]
    |=> !reset_busy_o)
    else $error("Global reset bit did not clear itself.");

  a_hz_defer: assert property (rst_pend_r
    && opmode_r.high_impedance_select && !wr_fire
    |=> reset_busy_o && $stable(opmode_r))
    else $error("Reset acted inside high-impedance mode.");

  a_hz_exit: assert property (rst_pend_r
    && !opmode_r.high_impedance_select && !wr_fire
    |=> !reset_busy_o && opmode_r == chg_opmode_type'(CHG_OPMODE_DEFAULT))
    else $error("Deferred reset did not run after high impedance.");

  a_freq_write: assert property (wr_opmode && !rst_fire
    |=> switch_freq_select_o == $past(wr_op_val.switch_freq_select))
    else $error("Frequency select did not follow the write.");

  a_fixed_write: assert property (wr_opmode && !rst_fire
    |=> fixed_freq_force_o == $past(wr_op_val.fixed_freq_force))
    else $error("Fixed frequency bit did not follow the write.");

  a_stat_write: assert property (wr_opmode && !rst_fire
    |=> stat_pin_enable_o == $past(wr_op_val.stat_pin_enable))
    else $error("Status pin enable did not follow the write.");

  a_int_hold: assert property (irq_pending_i
    && !opmode_r.int_reminder_enable |=> !int_n_o)
    else $error("Interrupt released without reminder.");

  a_int_clear: assert property (!irq_pending_i |=> int_n_o)
    else $error("Interrupt stayed low with nothing pending.");

  a_remind_gap: assert property (remind_on && rem_cnt_r == REL_START
    ##1 remind_on |-> int_n_o)
    else $error("Reminder did not release the interrupt.");

  a_remind_low: assert property (remind_on && rem_cnt_r < REL_START
    |=> !int_n_o)
    else $error("Reminder released the interrupt too early.");

  a_remind_reassert: assert property (remind_on && rem_cnt_r == REM_LAST
    ##1 remind_on |=> !int_n_o)
    else $error("Reminder did not reassert the interrupt.");

  a_hz_write: assert property (wr_opmode && !rst_fire
    |=> high_impedance_select_o == $past(wr_op_val.high_impedance_select))
    else $error("High impedance bit did not follow the write.");

  a_boost_gate: assert property (boost_mode_o
    |-> $past(opmode_r.boost_select)
    && (!$past(opmode_r.boost_pin_gating) || $past(otg_s2_r)))
    else $error("Boost mode ignored its gating.");

  a_gate_pin: assert property (opmode_r.boost_select
    && opmode_r.boost_pin_gating && !otg_s2_r |=> !boost_mode_o)
    else $error("Boost mode entered without the OTG pin.");

  a_boost_select: assert property (opmode_r.boost_select
    && !opmode_r.boost_pin_gating |=> boost_mode_o)
    else $error("Boost select did not enter boost mode.");

  a_boost_off: assert property (!opmode_r.boost_select
    |=> !boost_mode_o)
    else $error("Boost mode stayed on in charge mode.");

  a_rsvd_zero: assert property (opmode_r.rsvd5 == 1'b0
    && img_global_r[6:0] == CHG_RSVD_ZERO)
    else $error("Reserved bit read back as one.");

  a_rsvd_write: assert property (wr_opmode
    |=> opmode_r.rsvd5 == 1'b0)
    else $error("A write reached a reserved bit.");

  c_hz_deferred: cover property (rst_pend_r
    && opmode_r.high_impedance_select ##[1:50] rst_fire);
  c_remind_cycle: cover property (remind_on && rem_cnt_r == REM_LAST);
  c_boost_gated: cover property (boost_mode_o && opmode_r.boost_pin_gating);
  c_global_reset: cover property (wr_rst_req ##1 rst_fire);

endmodule : chg_core_ctrl

// *** tb/chg_i2c_host_model.sv ***
// Behavioural I2C host that reaches the charger control registers.
// Assumes the bench resolves the open-drain SDA wire with a pull-up.
`timescale 1ns/1ps
module chg_i2c_host_model
  import chg_pkg::*;
(
  // Bus pins
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  // SCL stands high between frames, so the link sees no stray edges.
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    #10 sda_oe_o = !b;
    #52.5 scl_o = 1'b1;
    r = sda_i;
    #62.5 scl_o = 1'b0;
  endtask : bit_io

  task automatic start_cond();
    #10 sda_oe_o = 1'b0;
    #52.5 scl_o = 1'b1;
    #62.5 sda_oe_o = 1'b1;
    #62.5 scl_o = 1'b0;
  endtask : start_cond

  // The gap after a stop lets a written value reach the register image.
  task automatic stop_cond();
    #10 sda_oe_o = 1'b1;
    #52.5 scl_o = 1'b1;
    #62.5 sda_oe_o = 1'b0;
    #300;
  endtask : stop_cond

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : put_byte

  task automatic write_reg(input logic [6:0] a, input logic [7:0] off,
                           input logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    a1 = 1'b0;
    a2 = 1'b0;
    start_cond();
    put_byte({a, 1'b0}, a0);
    if (a0)
    begin
      put_byte(off, a1);
      put_byte(d, a2);
    end
    stop_cond();
    ack = a0 & a1 & a2;
  endtask : write_reg

  // offset sent before the read data
  task automatic read_reg(input logic [7:0] off, output logic [7:0] d);
    logic a;
    logic r;
    start_cond();
    put_byte({CHG_I2C_ADDR, 1'b0}, a);
    put_byte(off, a);
    start_cond();
    put_byte({CHG_I2C_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop_cond();
  endtask : read_reg
endmodule : chg_i2c_host_model

// *** tb/chg_core_ctrl_test.sv ***
// Self-checking bench for the charger control register bank.
// Assumes the host model above and shortened reminder timing.
`timescale 1ns/1ps
module chg_core_ctrl_test
  import chg_pkg::*;
;
  localparam int REMIND = 200;
  localparam int RELEASE = 5;
  logic clk_i;
  logic rst_n_i;
  logic otg_pin_i;
  logic irq_pending_i;
  logic scl;
  logic host_oe;
  logic sda_w;
  logic sda_o;
  logic sda_oe;
  logic int_n_o;
  logic sw;
  logic fx;
  logic st;
  logic hz;
  logic bm;
  logic busy;
  logic ack;
  logic [7:0] d;
  logic [31:0] x;
  logic [31:0] seed;
  logic [7:0] highs;
  int bad_count;
  int samples_checked;
  wire logic [7:0] outs;

  assign outs = {3'h0, sw, fx, st, hz, bm};
  assign sda_w = host_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  chg_core_ctrl #(.REMIND_CYCLES(REMIND), .RELEASE_CYCLES(RELEASE))
    chg_core_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .otg_pin_i(otg_pin_i), .irq_pending_i(irq_pending_i),
    .int_n_o(int_n_o), .switch_freq_select_o(sw),
    .fixed_freq_force_o(fx), .stat_pin_enable_o(st),
    .high_impedance_select_o(hz), .boost_mode_o(bm),
    .reset_busy_o(busy));

  chg_i2c_host_model host_model (.scl_o(scl), .sda_oe_o(host_oe),
    .sda_i(sda_w));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected control outputs for an opmode value and OTG pin level.
  function automatic logic [7:0] exp_outs(logic [7:0] m, logic otg);
    return {3'h0, m[7], m[6], m[4], m[2], m[0] & (!m[1] | otg)};
  endfunction : exp_outs

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // Settling wait lets the control domain and outputs take the write.
  task automatic wr(input logic [7:0] off, input logic [7:0] v);
    logic a;
    host_model.write_reg(CHG_I2C_ADDR, off, v, a);
    check({7'h00, a}, 8'h01);
    repeat (8) @(posedge clk_i);
    #1;
  endtask : wr

  task automatic rd_check(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] v;
    host_model.read_reg(off, v);
    check(v, exp);
  endtask : rd_check

  task automatic count_highs(input int n);
    highs = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      #1;
      if (int_n_o === 1'b1)
        highs++;
    end
  endtask : count_highs

  initial
  begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    summarize();
  end

  initial
  begin
    rst_n_i = 1'b0;
    otg_pin_i = 1'b0;
    irq_pending_i = 1'b0;
    seed = 32'h0000003E;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check(outs, exp_outs(CHG_OPMODE_DEFAULT, 1'b0));
    check({7'h00, int_n_o}, 8'h01);
    check({7'h00, sda_o}, 8'h00);
    rd_check(CHG_OFF_GLOBAL_RESET, CHG_GLOBAL_RESET_DEFAULT);
    rd_check(CHG_OFF_OPMODE, CHG_OPMODE_DEFAULT);
    host_model.write_reg(CHG_I2C_ADDR ^ 7'h01, CHG_OFF_OPMODE, 8'h81, ack);
    check({7'h00, ack}, 8'h00);
    check(outs, exp_outs(CHG_OPMODE_DEFAULT, 1'b0));
    // High-impedance stays off here; it is covered with the deferred reset.
    for (int i = 0; i < 12; i++)
    begin
      x = rnd();
      d = (i == 0) ? 8'hFB : (x[7:0] & 8'hFB);
      @(posedge clk_i);
      otg_pin_i <= x[8];
      wr(CHG_OFF_OPMODE, d);
      check(outs, exp_outs(d, x[8]));
      rd_check(CHG_OFF_OPMODE, d & CHG_OPMODE_WMASK);
    end
    wr(CHG_OFF_OPMODE, 8'h04);
    check(outs, exp_outs(8'h04, x[8]));
    wr(CHG_OFF_OPMODE, 8'hC1);
    check(outs, exp_outs(8'hC1, x[8]));
    wr(CHG_OFF_GLOBAL_RESET, 8'h7F);
    check(outs, exp_outs(8'hC1, x[8]));
    rd_check(CHG_OFF_GLOBAL_RESET, 8'h00);
    wr(8'h05, 8'hFF);
    rd_check(8'h05, 8'h00);
    wr(CHG_OFF_GLOBAL_RESET, 8'h80);
    check(outs, exp_outs(CHG_OPMODE_DEFAULT, x[8]));
    check({7'h00, busy}, 8'h00);
    rd_check(CHG_OFF_GLOBAL_RESET, 8'h00);
    rd_check(CHG_OFF_OPMODE, CHG_OPMODE_DEFAULT);
    wr(CHG_OFF_OPMODE, 8'h84);
    wr(CHG_OFF_GLOBAL_RESET, 8'h80);
    check({7'h00, busy}, 8'h01);
    check(outs, exp_outs(8'h84, x[8]));
    rd_check(CHG_OFF_GLOBAL_RESET, 8'h80);
    wr(CHG_OFF_OPMODE, 8'h80);
    check(outs, exp_outs(CHG_OPMODE_DEFAULT, x[8]));
    check({7'h00, busy}, 8'h00);
    rd_check(CHG_OFF_GLOBAL_RESET, 8'h00);
    rd_check(CHG_OFF_OPMODE, CHG_OPMODE_DEFAULT);
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    count_highs(REMIND + 50);
    check(highs, 8'h00);
    wr(CHG_OFF_OPMODE, 8'h08);
    // This window of two whole periods holds exactly two release pulses.
    count_highs(2 * REMIND);
    check(highs, 8'(2 * RELEASE));
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    check({7'h00, int_n_o}, 8'h01);
    summarize();
  end
endmodule : chg_core_ctrl_test
